// ---- hw/bbd_pkg.sv ----
// package: register map, field positions and constants of the backup domain control
// Function
// - select clear gives 1Hz, set gives 1.024kHz
// - select writes ignored while oscillator enabled
// - oscillator enable is set-only until domain reset
// - failure flagged after 64 missed swings
// - failure detect enable is set-only
// - backup registers gated by access enable
// - access enable cleared only by device reset
// - domain reset pulse lasts one cycle
// - oscillator or failure detect enable bit written one blocks domain reset
// - domain reset clears drive, select, oscillator and failure detect enables, ready
// - domain reset needs protection unlock first
// - missing battery flag caught at reset, W1C
// - ready flag set when stable, domain reset clears
// - failure flag W1C or domain reset clears
// - brown-out flag set on battery, W1C
// - power-on flag latched only at startup
// - two 8-bit scratch registers kept on battery
// - high drive bit raises crystal drive
// - register inputs ignored while main power lost
package bbd_pkg;
	// register byte addresses (index times four)
	localparam logic [3:0] BBD_CTRL_IDX = 4'h0;
	localparam logic [3:0] BBD_STATUS_IDX = 4'h1;
	localparam logic [3:0] BBD_SCR_LO_IDX = 4'h2;
	localparam logic [3:0] BBD_SCR_HI_IDX = 4'h3;
	localparam logic [5:0] BBD_CTRL_ADDR = 6'h00;
	localparam logic [5:0] BBD_STATUS_ADDR = 6'h04;
	localparam logic [5:0] BBD_SCR_LO_ADDR = 6'h08;
	localparam logic [5:0] BBD_SCR_HI_ADDR = 6'h0C;
	// control field positions
	localparam int BBD_C_RESET = 0;
	localparam int BBD_C_DOMAIN_ACCESS_ENABLE = 1;
	localparam int BBD_C_FDEN = 2;
	localparam int BBD_C_OSCEN = 3;
	localparam int BBD_C_SEL = 4;
	localparam int BBD_C_HDRV = 5;
	// status field positions
	localparam int BBD_S_PODF = 0;
	localparam int BBD_S_BODF = 1;
	localparam int BBD_S_FAIL = 2;
	localparam int BBD_S_RDY = 3;
	localparam int BBD_S_PWR = 7;
	// reset values
	localparam logic [7:0] BBD_CTRL_RST = 8'h00;
	localparam logic [7:0] BBD_SCR_RST = 8'h00;
	// failure monitor threshold in missed swings
	localparam int BBD_FAIL_SWINGS = 64;
	// crystal swing period 30518 ns at 32.768kHz, timeout in core cycles
	localparam int BBD_CLK_NS = 100;
	localparam int BBD_SWING_NS = 30518;
	localparam int BBD_FAIL_CYCLES = (BBD_FAIL_SWINGS * BBD_SWING_NS + BBD_CLK_NS - 1) / BBD_CLK_NS;
	// axi responses
	localparam logic [1:0] BBD_RESP_OKAY = 2'b00;
	localparam logic [1:0] BBD_RESP_SLVERR = 2'b10;
endpackage

// ---- hw/bbd_osc_monitor.sv ----
// file: crystal failure monitor counting missed swings
`timescale 1ns/10ps
module bbd_osc_monitor
	import bbd_pkg::*;
#(
	parameter int TIMEOUT = BBD_FAIL_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic dom_rst,
	input wire logic enable,
	input wire logic swing,
	output logic fail_pulse
);
	logic [31:0] cnt; // cycles since last swing
	logic tripped; // one pulse per stall

	// count idle cycles, fire once at threshold
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 32'h0000_0000;
			tripped <= 1'b0;
			fail_pulse <= 1'b0;
		end else if (dom_rst || !enable || swing) begin
			cnt <= 32'h0000_0000;
			tripped <= 1'b0;
			fail_pulse <= 1'b0;
		end else begin
			fail_pulse <= 1'b0;
			if (cnt >= 32'(TIMEOUT) && !tripped) begin
				fail_pulse <= 1'b1;
				tripped <= 1'b1;
			end else if (!tripped) begin
				cnt <= cnt + 32'h0000_0001;
			end
		end
	end
endmodule // bbd_osc_monitor

// ---- hw/bbd_ctrl.sv ----
// file: battery backup domain control with axi4-lite register slave
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/10ps
module bbd_ctrl
	import bbd_pkg::*;
#(
	parameter int FAIL_TIMEOUT = BBD_FAIL_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst_n,
	// axi4-lite slave
	input wire logic [5:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [5:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// protection unlock from the configuration change protection logic
	input wire logic ccp_unlocked,
	// power and oscillator status
	input wire logic main_power_lost,
	input wire logic battery_supply_present,
	input wire logic backup_brownout_detector,
	input wire logic backup_poweron_detect,
	input wire logic crystal_stable,
	input wire logic crystal_swing,
	input wire logic presc_1hz,
	input wire logic presc_1khz,
	// outputs toward the oscillator and counter
	output logic crystal_osc_enable,
	output logic crystal_high_drive,
	output logic counter_clock_select,
	output logic counter_clock,
	output logic domain_reset
);
	// control state
	logic domain_access_enable; // gate for backup registers
	logic osc_failure_detect_enable; // monitor enable
	logic crystal_osc_ready; // ready flag
	logic crystal_failure_flag; // failure flag
	logic backup_power_missing; // no battery at reset
	logic backup_brownout_flag; // battery brown-out
	logic backup_poweron_flag; // battery power-on
	logic [7:0] scratch_store_low; // scratch 0
	logic [7:0] scratch_store_high; // scratch 1
	logic start_seen; // startup capture done
	logic fail_pulse; // from monitor

	// write channel state
	logic aw_held;
	logic w_held;
	logic [5:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_go;
	logic [7:0] wb;

	// accept address and data in either order, one write in flight
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign wr_go = aw_held && w_held && !s_axi_bvalid;
	assign wb = w_data[7:0];

	// hold address
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_held <= 1'b0;
			aw_addr <= 6'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end else if (wr_go) begin
			aw_held <= 1'b0;
		end
	end

	// hold data
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			w_held <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end else if (wr_go) begin
			w_held <= 1'b0;
		end
	end

	// decode of a write: low byte lane only, ignored while main power lost
	logic wr_ok; // byte lane present and power good
	logic wr_ctrl;
	logic wr_stat;
	logic wr_lo;
	logic wr_hi;
	logic addr_hit_w;
	assign wr_ok = wr_go && w_strb[0] && !main_power_lost;
	assign addr_hit_w = (aw_addr[1:0] == 2'b00) && (aw_addr[5:4] == 2'b00);
	assign wr_ctrl = wr_ok && addr_hit_w && aw_addr[3:2] == BBD_CTRL_IDX[1:0] && domain_access_enable;
	assign wr_stat = wr_ok && addr_hit_w && aw_addr[3:2] == BBD_STATUS_IDX[1:0];
	assign wr_lo = wr_ok && addr_hit_w && aw_addr[3:2] == BBD_SCR_LO_IDX[1:0] && domain_access_enable;
	assign wr_hi = wr_ok && addr_hit_w && aw_addr[3:2] == BBD_SCR_HI_IDX[1:0] && domain_access_enable;

	// write response, slverr on unmapped or blocked access
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= BBD_RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			if (!addr_hit_w || main_power_lost) begin
				s_axi_bresp <= BBD_RESP_SLVERR;
			end else if (aw_addr[3:2] != BBD_STATUS_IDX[1:0] && !domain_access_enable) begin
				s_axi_bresp <= BBD_RESP_SLVERR;
			end else begin
				s_axi_bresp <= BBD_RESP_OKAY;
			end
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// domain reset: one-cycle pulse, protected, blocked by oscillator or failure detect enable writes
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			domain_reset <= 1'b0;
		end else begin
			domain_reset <= wr_ctrl && wb[BBD_C_RESET] && ccp_unlocked
				&& !wb[BBD_C_OSCEN] && !wb[BBD_C_FDEN];
		end
	end

	// access enable: set-only, cleared by device reset
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			domain_access_enable <= 1'b0;
		end else if (wr_ok && addr_hit_w && aw_addr[3:2] == BBD_CTRL_IDX[1:0] && wb[BBD_C_DOMAIN_ACCESS_ENABLE]) begin
			domain_access_enable <= 1'b1;
		end
	end

	// oscillator enable, set-only until domain reset
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			crystal_osc_enable <= 1'b0;
		end else if (domain_reset) begin
			crystal_osc_enable <= 1'b0;
		end else if (wr_ctrl && wb[BBD_C_OSCEN]) begin
			crystal_osc_enable <= 1'b1;
		end
	end

	// failure detect enable, set-only until domain reset
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			osc_failure_detect_enable <= 1'b0;
		end else if (domain_reset) begin
			osc_failure_detect_enable <= 1'b0;
		end else if (wr_ctrl && wb[BBD_C_FDEN]) begin
			osc_failure_detect_enable <= 1'b1;
		end
	end

	// clock select, frozen while the oscillator runs
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			counter_clock_select <= 1'b0;
		end else if (domain_reset) begin
			counter_clock_select <= 1'b0;
		end else if (wr_ctrl && !crystal_osc_enable) begin
			counter_clock_select <= wb[BBD_C_SEL];
		end
	end

	// high drive bit
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			crystal_high_drive <= 1'b0;
		end else if (domain_reset) begin
			crystal_high_drive <= 1'b0;
		end else if (wr_ctrl) begin
			crystal_high_drive <= wb[BBD_C_HDRV];
		end
	end

	// counter clock source mux
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			counter_clock <= 1'b0;
		end else begin
			counter_clock <= counter_clock_select ? presc_1khz : presc_1hz;
		end
	end

	// ready flag: set once stable, cleared only by domain reset
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			crystal_osc_ready <= 1'b0;
		end else if (domain_reset) begin
			crystal_osc_ready <= 1'b0;
		end else if (crystal_osc_enable && crystal_stable) begin
			crystal_osc_ready <= 1'b1;
		end
	end

	// failure monitor
	bbd_osc_monitor #(
		.TIMEOUT(FAIL_TIMEOUT)
	) u_mon (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.dom_rst(domain_reset),
		.enable(osc_failure_detect_enable),
		.swing(crystal_swing),
		.fail_pulse(fail_pulse)
	);

	// failure flag: set wins, W1C, domain reset clears
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			crystal_failure_flag <= 1'b0;
		end else if (fail_pulse) begin
			crystal_failure_flag <= 1'b1;
		end else if (domain_reset) begin
			crystal_failure_flag <= 1'b0;
		end else if (wr_stat && domain_access_enable && wb[BBD_S_FAIL]) begin
			crystal_failure_flag <= 1'b0;
		end
	end

	// startup capture of supervision levels, one cycle after reset release
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			start_seen <= 1'b0;
		end else begin
			start_seen <= 1'b1;
		end
	end

	// missing-power flag
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			backup_power_missing <= 1'b0;
		end else if (!start_seen) begin
			backup_power_missing <= !battery_supply_present;
		end else if (wr_stat && wb[BBD_S_PWR]) begin
			backup_power_missing <= 1'b0;
		end
	end

	// power-on flag, latched at startup only
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			backup_poweron_flag <= 1'b0;
		end else if (!start_seen) begin
			backup_poweron_flag <= backup_poweron_detect;
		end else if (wr_stat && wb[BBD_S_PODF]) begin
			backup_poweron_flag <= 1'b0;
		end
	end

	// brown-out flag: only while on battery, set wins over clear
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			backup_brownout_flag <= 1'b0;
		end else if (main_power_lost && backup_brownout_detector) begin
			backup_brownout_flag <= 1'b1;
		end else if (wr_stat && wb[BBD_S_BODF]) begin
			backup_brownout_flag <= 1'b0;
		end
	end

	// scratch registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			scratch_store_low <= BBD_SCR_RST;
			scratch_store_high <= BBD_SCR_RST;
		end else begin
			if (wr_lo) begin
				scratch_store_low <= wb;
			end
			if (wr_hi) begin
				scratch_store_high <= wb;
			end
		end
	end

	// read channel
	logic [7:0] rd_byte;
	logic rd_err;
	logic addr_hit_r;
	assign s_axi_arready = !s_axi_rvalid;
	assign addr_hit_r = (s_axi_araddr[1:0] == 2'b00) && (s_axi_araddr[5:4] == 2'b00);

	// read mux with access gate, supervision flags visible without access enable while main power is present
	always_comb begin
		rd_byte = 8'h00;
		rd_err = !addr_hit_r || main_power_lost;
		if (addr_hit_r && !main_power_lost) begin
			case (s_axi_araddr[3:2])
				BBD_CTRL_IDX[1:0]: begin
					rd_err = !domain_access_enable;
					if (domain_access_enable) begin
						rd_byte = {2'b00, crystal_high_drive, counter_clock_select, crystal_osc_enable,
							osc_failure_detect_enable, domain_access_enable, 1'b0};
					end
				end
				BBD_STATUS_IDX[1:0]: begin
					rd_byte[BBD_S_PWR] = backup_power_missing;
					rd_byte[BBD_S_BODF] = backup_brownout_flag;
					rd_byte[BBD_S_PODF] = backup_poweron_flag;
					if (domain_access_enable) begin
						rd_byte[BBD_S_RDY] = crystal_osc_ready;
						rd_byte[BBD_S_FAIL] = crystal_failure_flag;
					end
				end
				BBD_SCR_LO_IDX[1:0]: begin
					rd_err = !domain_access_enable;
					rd_byte = domain_access_enable ? scratch_store_low : 8'h00;
				end
				default: begin
					rd_err = !domain_access_enable;
					rd_byte = domain_access_enable ? scratch_store_high : 8'h00;
				end
			endcase
		end
	end

	// read data register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= BBD_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h00_0000, rd_byte};
			s_axi_rresp <= rd_err ? BBD_RESP_SLVERR : BBD_RESP_OKAY;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule // bbd_ctrl

// ---- verif/bbd_ctrl_props.sv ----
// checker: timing relations at the ports of the backup domain control
`timescale 1ns/10ps
module bbd_ctrl_props
	import bbd_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_rvalid,
	input wire logic [1:0] s_axi_rresp,
	input wire logic [31:0] s_axi_rdata,
	input wire logic ccp_unlocked,
	input wire logic main_power_lost,
	input wire logic presc_1hz,
	input wire logic presc_1khz,
	input wire logic crystal_osc_enable,
	input wire logic crystal_high_drive,
	input wire logic counter_clock_select,
	input wire logic counter_clock,
	input wire logic domain_reset
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	// domain reset lasts a single cycle
	property p_rst_pulse;
		domain_reset |=> !domain_reset;
	endproperty
	a_rst_pulse: assert property (p_rst_pulse) else $error("domain reset longer than one cycle");
	// pulse comes with the write response
	property p_rst_edge;
		$rose(domain_reset) |-> $rose(s_axi_bvalid);
	endproperty
	a_rst_edge: assert property (p_rst_edge) else $error("domain reset not tied to a write");
	// only an unlocked write resets the domain
	property p_rst_lock;
		domain_reset |-> $past(ccp_unlocked);
	endproperty
	a_rst_lock: assert property (p_rst_lock) else $error("domain reset while locked");
	// reset clears the oscillator controls
	property p_rst_clr;
		domain_reset |=> !crystal_osc_enable && !counter_clock_select && !crystal_high_drive;
	endproperty
	a_rst_clr: assert property (p_rst_clr) else $error("controls kept after domain reset");
	// enabling the oscillator never resets
	property p_no_rst_en;
		$rose(crystal_osc_enable) |-> !domain_reset;
	endproperty
	a_no_rst_en: assert property (p_no_rst_en) else $error("reset with oscillator enable");
	// oscillator enable holds until domain reset
	property p_osc_sticky;
		crystal_osc_enable && !domain_reset |=> crystal_osc_enable;
	endproperty
	a_osc_sticky: assert property (p_osc_sticky) else $error("oscillator enable dropped");
	// select frozen while the oscillator runs
	property p_sel_hold;
		crystal_osc_enable && !domain_reset |=> $stable(counter_clock_select);
	endproperty
	a_sel_hold: assert property (p_sel_hold) else $error("select changed while running");
	// counter clock follows the selected prescaler a cycle later, not across reset release
	property p_clk_mux;
		$past(rst_n) |-> counter_clock == ($past(counter_clock_select) ? $past(presc_1khz) : $past(presc_1hz));
	endproperty
	a_clk_mux: assert property (p_clk_mux) else $error("wrong counter clock source");
	// reads refused while main power is lost
	property p_rd_lost;
		$rose(s_axi_rvalid) && $past(main_power_lost) |-> s_axi_rresp == BBD_RESP_SLVERR && s_axi_rdata == 32'h0;
	endproperty
	a_rd_lost: assert property (p_rd_lost) else $error("read served without main power");
	c_rst: cover property ($rose(domain_reset));
	c_rst_run: cover property (domain_reset && crystal_osc_enable);
	c_refused: cover property (s_axi_rvalid && s_axi_rresp == BBD_RESP_SLVERR);
endmodule // bbd_ctrl_props

// ---- verif/bbd_ctrl_tb.sv ----
// testbench: register level scenarios for the backup domain control
`timescale 1ns/10ps
module bbd_ctrl_tb
	import bbd_pkg::*;
();
	localparam logic [1:0] OK = BBD_RESP_OKAY;
	localparam logic [1:0] SE = BBD_RESP_SLVERR;
	localparam logic [5:0] CT = BBD_CTRL_ADDR;
	localparam logic [5:0] ST = BBD_STATUS_ADDR;
	localparam logic [5:0] SL = BBD_SCR_LO_ADDR;
	localparam logic [5:0] SH = BBD_SCR_HI_ADDR;
	logic core_clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [5:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic ccp_unlocked, main_power_lost, battery_supply_present, backup_brownout_detector;
	logic backup_poweron_detect, crystal_stable, crystal_swing, presc_1hz, presc_1khz;
	logic crystal_osc_enable, crystal_high_drive, counter_clock_select, counter_clock, domain_reset;
	int fails; // mismatch count
	int total_checks; // comparison count
	int rst_pulses = 0; // cycles with domain reset high
	// short failure timeout keeps the run brief
	bbd_ctrl #(.FAIL_TIMEOUT(20)) i_dut (
		.core_clk(core_clk), .rst_n(rst_n),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.ccp_unlocked(ccp_unlocked), .main_power_lost(main_power_lost),
		.battery_supply_present(battery_supply_present), .backup_brownout_detector(backup_brownout_detector),
		.backup_poweron_detect(backup_poweron_detect), .crystal_stable(crystal_stable),
		.crystal_swing(crystal_swing), .presc_1hz(presc_1hz), .presc_1khz(presc_1khz),
		.crystal_osc_enable(crystal_osc_enable), .crystal_high_drive(crystal_high_drive),
		.counter_clock_select(counter_clock_select), .counter_clock(counter_clock),
		.domain_reset(domain_reset)
	);
	// count cycles in which the domain reset pulse stands
	always @(posedge core_clk) begin
		if (domain_reset === 1'b1) rst_pulses <= rst_pulses + 1;
	end
	// 100 ns clock
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	// verdict and end of run
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// compare and count
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	// axi write, holds each channel until taken
	task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [1:0] er);
		int n;
		@(posedge core_clk);
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h00_0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && n < 50);
		s_axi_bready <= 1'b0;
		chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
		if (n >= 50) begin
			fails++;
			test_done();
		end
	endtask
	// axi read with expected byte and response
	task automatic rc(input logic [5:0] a, input logic [7:0] ed, input logic [1:0] er);
		int n;
		@(posedge core_clk);
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 50);
		s_axi_rready <= 1'b0;
		chk("rdata", {24'h00_0000, ed}, s_axi_rdata);
		chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
		if (n >= 50) begin
			fails++;
			test_done();
		end
	endtask
	// main sequence
	initial begin
		{rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		{ccp_unlocked, main_power_lost, battery_supply_present, backup_brownout_detector} = '0;
		{crystal_stable, crystal_swing, presc_1khz} = '0;
		backup_poweron_detect = 1'b1;
		presc_1hz = 1'b1;
		fails = 0;
		total_checks = 0;
		repeat (10) @(posedge core_clk);
		rst_n <= 1'b1;
		// startup flags and access gate
		rc(ST, 8'h81, OK);
		chk("counter_clock", 1, {31'h0, counter_clock});
		wr(SL, 8'h5a, SE);
		rc(SL, 8'h00, SE);
		wr(6'h10, 8'h00, SE);
		wr(CT, 8'h02, SE);
		wr(CT, 8'h00, OK);
		rc(CT, 8'h02, OK);
		$display("test access done");
		// scratch and flag clearing
		wr(SL, 8'h5a, OK);
		wr(SH, 8'ha5, OK);
		rc(SL, 8'h5a, OK);
		rc(SH, 8'ha5, OK);
		wr(ST, 8'h00, OK);
		rc(ST, 8'h81, OK);
		wr(ST, 8'h81, OK);
		rc(ST, 8'h00, OK);
		$display("test flags done");
		// battery operation
		main_power_lost <= 1'b1;
		backup_brownout_detector <= 1'b1;
		repeat (2) @(posedge core_clk);
		backup_brownout_detector <= 1'b0;
		wr(SL, 8'h00, SE);
		rc(SL, 8'h00, SE);
		main_power_lost <= 1'b0;
		rc(ST, 8'h02, OK);
		rc(SL, 8'h5a, OK);
		wr(ST, 8'h02, OK);
		rc(ST, 8'h00, OK);
		$display("test battery done");
		// oscillator, select and drive
		wr(CT, 8'h32, OK);
		chk("high_drive", 1, {31'h0, crystal_high_drive});
		presc_1hz <= 1'b0;
		presc_1khz <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk("counter_clock", 1, {31'h0, counter_clock});
		wr(CT, 8'h3a, OK);
		wr(CT, 8'h02, OK);
		chk("osc_enable", 1, {31'h0, crystal_osc_enable});
		chk("clock_select", 1, {31'h0, counter_clock_select});
		rc(CT, 8'h1a, OK);
		crystal_stable <= 1'b1;
		repeat (3) @(posedge core_clk);
		rc(ST, 8'h08, OK);
		$display("test oscillator done");
		// failure monitor
		wr(CT, 8'h1e, OK);
		rc(ST, 8'h08, OK);
		repeat (30) @(posedge core_clk);
		rc(ST, 8'h0c, OK);
		wr(CT, 8'h02, OK);
		rc(CT, 8'h1e, OK);
		crystal_swing <= 1'b1;
		wr(ST, 8'h04, OK);
		rc(ST, 8'h08, OK);
		$display("test monitor done");
		// domain reset
		wr(CT, 8'h03, OK);
		rc(CT, 8'h1e, OK);
		ccp_unlocked <= 1'b1;
		wr(CT, 8'h0b, OK);
		rc(CT, 8'h1e, OK);
		wr(CT, 8'h03, OK);
		rc(CT, 8'h02, OK);
		rc(ST, 8'h00, OK);
		chk("osc_enable", 0, {31'h0, crystal_osc_enable});
		chk("reset_pulses", 1, rst_pulses);
		$display("test domain reset done");
		test_done();
	end
endmodule // bbd_ctrl_tb
bind bbd_ctrl bbd_ctrl_props i_props (
	.core_clk(core_clk), .rst_n(rst_n), .s_axi_bvalid(s_axi_bvalid), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rresp(s_axi_rresp), .s_axi_rdata(s_axi_rdata), .ccp_unlocked(ccp_unlocked),
	.main_power_lost(main_power_lost), .presc_1hz(presc_1hz), .presc_1khz(presc_1khz),
	.crystal_osc_enable(crystal_osc_enable), .crystal_high_drive(crystal_high_drive),
	.counter_clock_select(counter_clock_select), .counter_clock(counter_clock), .domain_reset(domain_reset)
);
